// [common/c3d_defs.svh]
// Register offsets, field positions, reset values and codes for the channel 3 clock block.
`ifndef C3D_DEFS_SVH
`define C3D_DEFS_SVH

`define C3D_ADDR_DIVCNT   10'h199
`define C3D_ADDR_DIVCTL   10'h19A
`define C3D_ADDR_OUTCTL   10'h19B
`define C3D_ADDR_PRESC    10'h1E0
`define C3D_ADDR_FESEL    10'h1E1

`define C3D_RST_DIVCNT    8'h00
`define C3D_RST_DIVCTL    8'h00
`define C3D_RST_OUTCTL    8'h00
`define C3D_RST_PRESC     8'h00
`define C3D_RST_FESEL     8'h00

`define C3D_DIVCTL_BYP    7
`define C3D_DIVCTL_IGN    6
`define C3D_DIVCTL_FRC    5
`define C3D_DIVCTL_STH    4
`define C3D_OUTCTL_PD     2
`define C3D_OUTCTL_DIR    1
`define C3D_OUTCTL_DCCD   0
`define C3D_FESEL_OSC     1
`define C3D_FESEL_BYP     0

`define C3D_PRESC_STATIC  3'h5
`define C3D_PRESC_BYPASS  3'h6
`define C3D_FE_OSC_CODE   2'h2
`define C3D_FE_EXT_CODE   2'h0

`endif

// [common/c3d_pkg.sv]
// Types shared by the channel 3 clock block.
package c3d_pkg;

   typedef enum logic [1:0] {
      C3D_ST_HOLD  = 2'b00,
      C3D_ST_PHASE = 2'b01,
      C3D_ST_RUN   = 2'b11
   } c3d_state_t;

   typedef struct packed {
      logic group3_output_c;
      logic group3_output_b;
      logic group3_output_a;
   } c3d_grp_t;

endpackage

// [hdl/c3d_top.sv]
// Channel 3 divider, output routing and front-end prescaler control.
//
// Contract
// - Bypass bit set: divider powered down, its input passed straight to its output.
// - Ignore-sync clear: divider obeys chip sync; set: sync is disregarded entirely.
// - Force acts only with ignore-sync: divider runs when force is 0, output held at start-high level when force is 1.
// - In bypass the force bit is ignored; output polarity inversion still applies.
// - Start-high bit sets divider output level after sync: 0 low, 1 high.
// - Four-bit phase offset field for the divider, reset to zero.
// - Channel power-down puts all three output pairs into safe powered-down state.
// - Direct-to-output clear: three outputs fed from the channel divider, the reset state.
// - Direct-to-output set: select 10b routes oscillator, 00b external clock, 01b and 11b keep the channel divider.
// - Duty-cycle correction active when disable bit is 0, off when 1.
// - Prescaler code 000-100 divides by 2-6, 101 static, 110 divides by one.
// - Divider output low for low count plus one, high for high count plus one.
// - Front-end select picks external clock or oscillator; oscillator forbids prescaler bypass.
// - Active sync holds the channel static; its release restarts the channel.
`timescale 1ns/1ps
`include "c3d_defs.svh"

module c3d_top
   import c3d_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Register port.
   input  wire logic [9:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   output logic      [7:0]  reg_rdata_out,
   // Clock sources and chip-level sync.
   input  wire logic        osc_level_in,
   input  wire logic        ext_level_in,
   input  wire logic        sync_n_in,
   input  wire logic [2:0]  polarity_invert_in,
   // Channel outputs.
   output c3d_grp_t         group3_outputs_out,
   output logic             channel_power_down_out,
   output logic             duty_cycle_correction_out
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] divcnt_r, divctl_r, outctl_r, presc_r, fesel_r;
   logic [7:0] divcnt_nxt, divctl_nxt, outctl_nxt, presc_nxt, fesel_nxt, rdata_nxt;

   always_comb begin
      divcnt_nxt = divcnt_r;
      divctl_nxt = divctl_r;
      outctl_nxt = outctl_r;
      presc_nxt  = presc_r;
      fesel_nxt  = fesel_r;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `C3D_ADDR_DIVCNT: divcnt_nxt = reg_wdata_in;
            `C3D_ADDR_DIVCTL: divctl_nxt = reg_wdata_in;
            `C3D_ADDR_OUTCTL: outctl_nxt = {5'h00, reg_wdata_in[2:0]};
            `C3D_ADDR_PRESC:  presc_nxt  = {5'h00, reg_wdata_in[2:0]};
            `C3D_ADDR_FESEL:  fesel_nxt  = {6'h00, reg_wdata_in[1:0]};
            default: ;
         endcase
      end
      unique case (reg_addr_in)
         `C3D_ADDR_DIVCNT: rdata_nxt = divcnt_r;
         `C3D_ADDR_DIVCTL: rdata_nxt = divctl_r;
         `C3D_ADDR_OUTCTL: rdata_nxt = outctl_r;
         `C3D_ADDR_PRESC:  rdata_nxt = presc_r;
         `C3D_ADDR_FESEL:  rdata_nxt = fesel_r;
         default:          rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         divcnt_r      <= `C3D_RST_DIVCNT;
         divctl_r      <= `C3D_RST_DIVCTL;
         outctl_r      <= `C3D_RST_OUTCTL;
         presc_r       <= `C3D_RST_PRESC;
         fesel_r       <= `C3D_RST_FESEL;
         reg_rdata_out <= 8'h00;
      end else begin
         divcnt_r      <= divcnt_nxt;
         divctl_r      <= divctl_nxt;
         outctl_r      <= outctl_nxt;
         presc_r       <= presc_nxt;
         fesel_r       <= fesel_nxt;
         reg_rdata_out <= rdata_nxt;
      end
   end

   logic       byp, ign, frc, sth, pd, dir;
   logic [3:0] phase, low_cnt, high_cnt;
   assign byp      = divctl_r[`C3D_DIVCTL_BYP];
   assign ign      = divctl_r[`C3D_DIVCTL_IGN];
   assign frc      = divctl_r[`C3D_DIVCTL_FRC];
   assign sth      = divctl_r[`C3D_DIVCTL_STH];
   assign phase    = divctl_r[3:0];
   assign pd       = outctl_r[`C3D_OUTCTL_PD];
   assign dir      = outctl_r[`C3D_OUTCTL_DIR];
   assign low_cnt  = divcnt_r[7:4];
   assign high_cnt = divcnt_r[3:0];
   assign duty_cycle_correction_out = ~outctl_r[`C3D_OUTCTL_DCCD];
   assign channel_power_down_out    = pd;

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   // Returns the divide ratio, zero meaning a static output.
   function automatic logic [2:0] presc_ratio(input logic [2:0] code, input logic osc,
                                              input logic fe_byp);
      if (fe_byp && !osc)
         presc_ratio = 3'h1;
      else if (code == `C3D_PRESC_BYPASS)
         presc_ratio = osc ? 3'h2 : 3'h1;
      else if (code > 3'h4)
         presc_ratio = 3'h0;
      else
         presc_ratio = code + 3'h2;
   endfunction

   logic       osc_sel, src_lvl, tick, plvl_r, plvl_nxt;
   logic [2:0] ratio, pcnt_r, pcnt_nxt;
   assign osc_sel = fesel_r[`C3D_FESEL_OSC];
   assign src_lvl = osc_sel ? osc_level_in : ext_level_in;
   assign ratio   = presc_ratio(presc_r[2:0], osc_sel, fesel_r[`C3D_FESEL_BYP]);

   always_comb begin
      pcnt_nxt = 3'h0;
      plvl_nxt = 1'b0;
      tick     = 1'b0;
      if (ratio == 3'h1) begin
         plvl_nxt = src_lvl;
         tick     = 1'b1;
      end else if (ratio != 3'h0) begin
         tick     = (pcnt_r >= ratio - 3'h1);
         pcnt_nxt = tick ? 3'h0 : pcnt_r + 3'h1;
         plvl_nxt = (pcnt_nxt < {1'b0, ratio[2:1]});
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pcnt_r <= 3'h0;
         plvl_r <= 1'b0;
      end else begin
         pcnt_r <= pcnt_nxt;
         plvl_r <= plvl_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Channel divider
   // ---------------------------------------------------------------
   c3d_state_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic       lvl_r, lvl_nxt, sync_act, forced;
   assign sync_act = ~sync_n_in & ~ign;
   assign forced   = ign & frc;

   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      lvl_nxt = lvl_r;
      if (forced) begin
         st_nxt  = C3D_ST_RUN;
         cnt_nxt = 4'h0;
         lvl_nxt = sth;
      end else if (sync_act) begin
         st_nxt  = C3D_ST_HOLD;
         cnt_nxt = 4'h0;
         lvl_nxt = sth;
      end else begin
         unique case (st_r)
            C3D_ST_HOLD: begin
               st_nxt  = (phase == 4'h0) ? C3D_ST_RUN : C3D_ST_PHASE;
               cnt_nxt = 4'h0;
               lvl_nxt = sth;
            end
            C3D_ST_PHASE: begin
               lvl_nxt = sth;
               if (tick) begin
                  if (cnt_r + 4'h1 >= phase) begin
                     st_nxt  = C3D_ST_RUN;
                     cnt_nxt = 4'h0;
                  end else begin
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            C3D_ST_RUN: begin
               if (tick) begin
                  if (cnt_r == (lvl_r ? high_cnt : low_cnt)) begin
                     cnt_nxt = 4'h0;
                     lvl_nxt = ~lvl_r;
                  end else begin
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            default: begin
               st_nxt  = C3D_ST_HOLD;
               cnt_nxt = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r  <= C3D_ST_HOLD;
         cnt_r <= 4'h0;
         lvl_r <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Output routing
   // ---------------------------------------------------------------
   logic     div_out, chan_lvl;
   c3d_grp_t grp_nxt;
   assign div_out = byp ? plvl_r : lvl_r;

   always_comb begin
      chan_lvl = div_out;
      if (dir && fesel_r[1:0] == `C3D_FE_OSC_CODE)
         chan_lvl = osc_level_in;
      else if (dir && fesel_r[1:0] == `C3D_FE_EXT_CODE)
         chan_lvl = ext_level_in;
      grp_nxt.group3_output_a = ~pd & (chan_lvl ^ polarity_invert_in[0]);
      grp_nxt.group3_output_b = ~pd & (chan_lvl ^ polarity_invert_in[1]);
      grp_nxt.group3_output_c = ~pd & (chan_lvl ^ polarity_invert_in[2]);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         group3_outputs_out <= '0;
      else
         group3_outputs_out <= grp_nxt;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_byp_pass;
      byp && !pd && !dir |=> group3_outputs_out.group3_output_a ==
         $past(plvl_r ^ polarity_invert_in[0]);
   endproperty
   a_byp_pass: assert property (p_byp_pass) else $error("Bypass path wrong.");
   property p_ign_sync;
      ign && !frc && st_r == C3D_ST_RUN && !sync_n_in |=> st_r == C3D_ST_RUN;
   endproperty
   a_ign_sync: assert property (p_ign_sync) else $error("Ignored sync acted.");
   property p_force;
      forced ##1 forced |-> lvl_r == $past(sth);
   endproperty
   a_force: assert property (p_force) else $error("Forced level wrong.");
   property p_start;
      !forced && !sync_act && st_r == C3D_ST_PHASE && tick && cnt_r + 4'h1 >= phase
         |=> st_r == C3D_ST_RUN && lvl_r == $past(sth);
   endproperty
   a_start: assert property (p_start) else $error("Start level wrong.");
   property p_pd;
      pd |=> group3_outputs_out == '0;
   endproperty
   a_pd: assert property (p_pd) else $error("Power-down not honoured.");
   property p_direct;
      dir && !pd && fesel_r[1:0] == `C3D_FE_OSC_CODE |=>
         group3_outputs_out.group3_output_b == $past(osc_level_in ^ polarity_invert_in[1]);
   endproperty
   a_direct: assert property (p_direct) else $error("Direct route wrong.");
   property p_static;
      presc_r[2:0] == `C3D_PRESC_STATIC && !fesel_r[`C3D_FESEL_BYP] [*2] |-> !plvl_r;
   endproperty
   a_static: assert property (p_static) else $error("Prescaler not static.");
   property p_toggle;
      !forced && !sync_act && st_r == C3D_ST_RUN && tick && !lvl_r && cnt_r == low_cnt
         |=> lvl_r;
   endproperty
   a_toggle: assert property (p_toggle) else $error("Low phase length wrong.");
   property p_hold;
      sync_act && !forced |=> st_r == C3D_ST_HOLD && lvl_r == $past(sth);
   endproperty
   a_hold: assert property (p_hold) else $error("Sync hold missed.");

endmodule // c3d_top

// [testbench/tb.sv]
// Self-checking testbench for the channel 3 clock block.
`timescale 1ns/1ps
`include "c3d_defs.svh"

module tb
   import c3d_pkg::*;
;
   logic       clk_in             = 1'b0;
   logic       rst_n_in           = 1'b0;
   logic [9:0] reg_addr_in        = 10'h000;
   logic [7:0] reg_wdata_in       = 8'h00;
   logic       reg_wr_in          = 1'b0;
   logic [7:0] reg_rdata_out;
   logic       osc_level_in       = 1'b0;
   logic       ext_level_in       = 1'b0;
   logic       sync_n_in          = 1'b1;
   logic [2:0] polarity_invert_in = 3'h0;
   c3d_grp_t   group3_outputs_out;
   logic       channel_power_down_out;
   logic       duty_cycle_correction_out;
   int         error_cnt          = 0;
   int         cmp_count          = 0;
   int         cycles             = 0;
   int         highs;
   int         flips;
   logic       e;

   always #5 clk_in = ~clk_in;

   c3d_top u_c3d_top (
      .clk_in                    (clk_in),
      .rst_n_in                  (rst_n_in),
      .reg_addr_in               (reg_addr_in),
      .reg_wdata_in              (reg_wdata_in),
      .reg_wr_in                 (reg_wr_in),
      .reg_rdata_out             (reg_rdata_out),
      .osc_level_in              (osc_level_in),
      .ext_level_in              (ext_level_in),
      .sync_n_in                 (sync_n_in),
      .polarity_invert_in        (polarity_invert_in),
      .group3_outputs_out        (group3_outputs_out),
      .channel_power_down_out    (channel_power_down_out),
      .duty_cycle_correction_out (duty_cycle_correction_out)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_addr_in  = a;
      reg_wdata_in = d;
      reg_wr_in    = 1'b1;
      @(negedge clk_in);
      reg_wr_in    = 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      reg_addr_in = a;
      repeat (2) @(negedge clk_in);
      chk("reg_rdata_out", exp, reg_rdata_out);
   endtask

   // Counts high samples and level changes of output a over n cycles.
   task automatic measure(input int n);
      logic prev;
      @(negedge clk_in);
      prev  = group3_outputs_out.group3_output_a;
      highs = 0;
      flips = 0;
      repeat (n) begin
         @(negedge clk_in);
         if (group3_outputs_out.group3_output_a === 1'b1) highs++;
         if (group3_outputs_out.group3_output_a !== prev) flips++;
         prev = group3_outputs_out.group3_output_a;
      end
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         $display("FAIL timeout expected 20000 seen %0d", cycles);
         stop_test();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (16) @(negedge clk_in);
      rst_n_in = 1'b1;
      rd(`C3D_ADDR_DIVCNT, 8'h00);
      rd(`C3D_ADDR_DIVCTL, 8'h00);
      rd(`C3D_ADDR_OUTCTL, 8'h00);
      rd(`C3D_ADDR_PRESC, 8'h00);
      rd(`C3D_ADDR_FESEL, 8'h00);
      rd(10'h3FF, 8'h00);
      chk("duty_cycle_correction_out", 8'h01, {7'h0, duty_cycle_correction_out});
      chk("channel_power_down_out", 8'h00, {7'h0, channel_power_down_out});
      $display("Test reset values done");

      ext_level_in = 1'b1;
      wr(`C3D_ADDR_OUTCTL, 8'hFF);
      rd(`C3D_ADDR_OUTCTL, 8'h07);
      chk("duty_cycle_correction_out", 8'h00, {7'h0, duty_cycle_correction_out});
      chk("channel_power_down_out", 8'h01, {7'h0, channel_power_down_out});
      chk("group3_outputs_out", 8'h00, {5'h0, group3_outputs_out});
      wr(`C3D_ADDR_PRESC, 8'hFF);
      rd(`C3D_ADDR_PRESC, 8'h07);
      wr(`C3D_ADDR_FESEL, 8'hFF);
      rd(`C3D_ADDR_FESEL, 8'h03);
      wr(`C3D_ADDR_DIVCTL, 8'hA5);
      rd(`C3D_ADDR_DIVCTL, 8'hA5);
      wr(`C3D_ADDR_DIVCNT, 8'h5A);
      rd(`C3D_ADDR_DIVCNT, 8'h5A);
      $display("Test register access done");

      wr(`C3D_ADDR_DIVCTL, 8'h00);
      wr(`C3D_ADDR_PRESC, 8'h00);
      wr(`C3D_ADDR_OUTCTL, 8'h02);
      for (int i = 0; i < 4; i++) begin
         wr(`C3D_ADDR_FESEL, (i < 2) ? 8'h02 : 8'h00);
         osc_level_in = i[0];
         ext_level_in = ~i[0];
         e = (i < 2) ? i[0] : ~i[0];
         repeat (4) @(negedge clk_in);
         chk("group3_outputs_out", {5'h0, {3{e}}}, {5'h0, group3_outputs_out});
      end
      // Select 01b keeps the divider: low 6 and high 11 ticks give 4 changes in 34 cycles.
      wr(`C3D_ADDR_FESEL, 8'h01);
      repeat (8) @(negedge clk_in);
      measure(34);
      chk("output_a_toggles", 8'h04, 8'(flips));
      $display("Test direct routing done");

      // Bypassed divider with force set shows the raw prescaler rate.
      wr(`C3D_ADDR_OUTCTL, 8'h00);
      wr(`C3D_ADDR_FESEL, 8'h00);
      ext_level_in = 1'b0;
      wr(`C3D_ADDR_DIVCTL, 8'hE0);
      for (int c = 0; c < 6; c++) begin
         wr(`C3D_ADDR_PRESC, 8'(c));
         repeat (8) @(negedge clk_in);
         measure(60);
         chk("output_a_toggles", (c == 5) ? 8'h00 : 8'(120 / (c + 2)), 8'(flips));
      end
      wr(`C3D_ADDR_PRESC, 8'h06);
      ext_level_in       = 1'b1;
      polarity_invert_in = 3'h5;
      repeat (4) @(negedge clk_in);
      chk("group3_outputs_out", 8'h02, {5'h0, group3_outputs_out});
      polarity_invert_in = 3'h0;
      // With the oscillator selected the prescaler bypass is refused: ratio stays two.
      wr(`C3D_ADDR_FESEL, 8'h03);
      repeat (8) @(negedge clk_in);
      measure(60);
      chk("output_a_toggles", 8'h3C, 8'(flips));
      wr(`C3D_ADDR_FESEL, 8'h00);
      $display("Test prescaler and bypass done");

      wr(`C3D_ADDR_DIVCTL, 8'h00);
      wr(`C3D_ADDR_DIVCNT, 8'h21);
      repeat (8) @(negedge clk_in);
      measure(60);
      chk("output_a_highs", 8'h18, 8'(highs));
      chk("output_a_toggles", 8'h18, 8'(flips));
      $display("Test divider counts done");

      wr(`C3D_ADDR_DIVCTL, 8'h10);
      sync_n_in = 1'b0;
      repeat (4) @(negedge clk_in);
      measure(20);
      chk("output_a_highs", 8'h14, 8'(highs));
      chk("output_a_toggles", 8'h00, 8'(flips));
      wr(`C3D_ADDR_DIVCNT, 8'h00);
      wr(`C3D_ADDR_DIVCTL, 8'h08);
      repeat (4) @(negedge clk_in);
      sync_n_in = 1'b1;
      measure(6);
      chk("output_a_highs", 8'h00, 8'(highs));
      repeat (10) @(negedge clk_in);
      measure(20);
      chk("output_a_toggles", 8'h14, 8'(flips));
      // With ignore-sync set the divider keeps toggling through an active sync.
      wr(`C3D_ADDR_DIVCTL, 8'h40);
      sync_n_in = 1'b0;
      repeat (4) @(negedge clk_in);
      measure(20);
      chk("output_a_toggles", 8'h14, 8'(flips));
      sync_n_in = 1'b1;
      $display("Test sync and phase done");

      wr(`C3D_ADDR_DIVCTL, 8'h70);
      repeat (4) @(negedge clk_in);
      measure(20);
      chk("output_a_highs", 8'h14, 8'(highs));
      $display("Test force done");
      stop_test();
   end
endmodule // tb
